// >>> design/dpi_pkg.sv
// Constants, opcodes and decode helpers for the debug pipeline inject sequencer
// Summary of operation
// - Status-write opcode 0xE12FF000 copies general register zero into the status word.
// - Two no-operations follow; status word changes when opcode reaches execute.
// - Load-multiple base 0xE89E0000, bit list 0..15, bit 0 is register zero.
// - Data words in cycles 4..N+3, optional counter is the last of them at N+3, last write N+5.
// - Store-multiple base 0xE88E0000 writes up to 15 registers at register fourteen.
// - Resume command makes the core execute a flagged store-multiple at system speed.
// - A no-operation with the system-speed flag marks the next injected instruction.
// - Each debug-state pipeline advance is one debug clock cycle.
package dpi_pkg;
  localparam logic [31:0] STATUS_WRITE_OP = 32'hE12FF000;
  localparam logic [15:0] LOAD_MULTI_HI = 16'hE89E;
  localparam logic [15:0] STORE_MULTI_HI = 16'hE88E;
  localparam logic [15:0] STORE_LIST_MASK = 16'h7FFF;
  localparam logic [3:0] ADDR_REG_IDX = 4'hE;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [31:0] INSTR_BYTES = 32'h00000004;
  localparam logic [31:0] PSW_RESET = 32'h00000000;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [2:0] TAIL_EDGES = 3'h2;
  localparam logic [2:0] TAIL_EDGES_PC = 3'h4;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {OP_NOP, OP_STATUS, OP_LOAD, OP_STORE} dpi_op_t;

  function automatic dpi_op_t dpi_decode(input logic [31:0] w);
    if (w == STATUS_WRITE_OP) return OP_STATUS;
    if (w[31:16] == LOAD_MULTI_HI) return OP_LOAD;
    if (w[31:16] == STORE_MULTI_HI) return OP_STORE;
    return OP_NOP;
  endfunction : dpi_decode

  function automatic logic [3:0] dpi_low_idx(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (l[i]) r = 4'(i);
    return r;
  endfunction : dpi_low_idx

  function automatic logic [4:0] dpi_count(input logic [15:0] l);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++)
      c = c + {4'h0, l[i]};
    return c;
  endfunction : dpi_count
endpackage : dpi_pkg

// >>> design/dpi_fifo.sv
// Parameterised valid/ready FIFO for store-multiple memory writes
`timescale 1ns/1ns
`default_nettype none
module dpi_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dpi_fifo_st_t;

  dpi_fifo_st_t s_r, s_nxt;
  logic push, pop;

  assign in_ready_o = (s_r.cnt != FULL_CNT);
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wr] = in_data_i;
      s_nxt.wr = (s_r.wr == AW'(DEPTH-1)) ? '0 : s_r.wr + 1'b1;
    end
    if (pop)
      s_nxt.rd = (s_r.rd == AW'(DEPTH-1)) ? '0 : s_r.rd + 1'b1;
    case ({push, pop})
      2'b10: s_nxt.cnt = s_r.cnt + 1'b1;
      2'b01: s_nxt.cnt = s_r.cnt - 1'b1;
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  cnt_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) s_r.cnt <= FULL_CNT)
    else $error("fifo count above depth");
endmodule : dpi_fifo
`default_nettype wire

// >>> design/dpi_sequencer.sv
// Debug-state pipeline inject sequencer: status write, load-multiple, store-multiple
`timescale 1ns/1ns
`default_nettype none
module dpi_sequencer
  import dpi_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic debug_clock_i,
  input wire logic resume_i,
  input wire logic [31:0] scan_word_i,
  input wire logic system_speed_flag_i,
  output logic [31:0] psw_o,
  output logic reg_wr_o,
  output logic [3:0] reg_wr_idx_o,
  output logic [31:0] reg_wr_data_o,
  output logic load_busy_o,
  output logic debug_acknowledge_o,
  output logic memory_request_n_o,
  output logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  output logic [31:0] mem_wr_addr_o,
  output logic [31:0] mem_wr_data_o
);
  typedef enum logic [2:0] {ST_HALT, ST_LOAD, ST_TAIL, ST_RUN, ST_DRAIN} dpi_state_t;

  typedef struct packed {
    logic [1:0] dck_s;
    logic dck_prev;
    logic [1:0] res_s;
    logic res_prev;
    logic [32:0] word_s1;
    logic [32:0] word_s2;
    logic [31:0] fetch;
    logic fetch_v;
    logic fetch_m;
    logic [31:0] decode;
    logic decode_v;
    logic decode_m;
    logic mark;
    dpi_state_t st;
    logic [15:0] list;
    logic [4:0] left;
    logic [2:0] tail;
    logic p1_v;
    logic [3:0] p1_i;
    logic [31:0] p1_d;
    logic p2_v;
    logic [3:0] p2_i;
    logic [31:0] p2_d;
    logic [15:0][31:0] gr;
    logic [31:0] addr;
    logic [31:0] psw;
    logic reg_wr;
    logic [3:0] reg_idx;
    logic [31:0] reg_data;
    logic busy;
    logic dbg_ack;
  } dpi_seq_st_t;

  dpi_seq_st_t s_r, s_nxt;
  logic de, re, push, fifo_ready, fifo_valid;
  logic [31:0] w, gr0, p2_d, addr;
  logic w_flag, exec_ok;
  logic [3:0] push_idx, p2_i;
  logic [63:0] fifo_out;

  // Link pins are only read after the second flop
  assign de = s_r.dck_s[1] && !s_r.dck_prev;
  assign re = s_r.res_s[1] && !s_r.res_prev;
  assign w = s_r.word_s2[31:0];
  assign w_flag = s_r.word_s2[32];
  assign gr0 = s_r.gr[0];
  assign p2_d = s_r.p2_d;
  assign p2_i = s_r.p2_i;
  assign addr = s_r.addr;
  assign exec_ok = s_r.st == ST_HALT && s_r.decode_v;
  assign push_idx = dpi_low_idx(s_r.list);
  assign push = s_r.st == ST_RUN && s_r.list != '0 && fifo_ready;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.dck_s = {s_r.dck_s[0], debug_clock_i};
    s_nxt.dck_prev = s_r.dck_s[1];
    s_nxt.res_s = {s_r.res_s[0], resume_i};
    s_nxt.res_prev = s_r.res_s[1];
    s_nxt.word_s1 = {system_speed_flag_i, scan_word_i};
    s_nxt.word_s2 = s_r.word_s1;
    s_nxt.reg_wr = 1'b0;
    if (de && s_r.st inside {ST_HALT, ST_LOAD, ST_TAIL})
    begin
      // One pipeline advance per debug clock edge
      s_nxt.decode = s_r.fetch;
      s_nxt.decode_v = s_r.fetch_v;
      s_nxt.decode_m = s_r.fetch_m;
      s_nxt.fetch = w;
      // Data words are not instructions, so they pass through fetch and decode marked invalid
      s_nxt.fetch_v = s_r.st != ST_LOAD;
      s_nxt.fetch_m = s_r.mark;
      s_nxt.mark = w_flag;
      if (s_r.p2_v)
      begin
        s_nxt.gr[s_r.p2_i] = s_r.p2_d;
        s_nxt.reg_wr = 1'b1;
        s_nxt.reg_idx = s_r.p2_i;
        s_nxt.reg_data = s_r.p2_d;
      end
      s_nxt.p2_v = s_r.p1_v;
      s_nxt.p2_i = s_r.p1_i;
      s_nxt.p2_d = s_r.p1_d;
      s_nxt.p1_v = 1'b0;
    end
    case (s_r.st)
      ST_HALT:
      begin
        if (de && s_r.decode_v)
        begin
          case (dpi_decode(s_r.decode))
            OP_STATUS: s_nxt.psw = s_r.gr[0];
            OP_LOAD:
            begin
              s_nxt.list = s_r.decode[15:0];
              s_nxt.left = dpi_count(s_r.decode[15:0]);
              s_nxt.tail = s_r.decode[PC_IDX] ? TAIL_EDGES_PC : TAIL_EDGES;
              s_nxt.st = (s_r.decode[15:0] == '0) ? ST_TAIL : ST_LOAD;
            end
            default: s_nxt.st = ST_HALT;
          endcase
        end
        else if (re && !de && exec_ok && s_r.decode_m && dpi_decode(s_r.decode) == OP_STORE)
        begin
          // Program counter is never stored
          s_nxt.list = s_r.decode[15:0] & STORE_LIST_MASK;
          s_nxt.addr = s_r.gr[ADDR_REG_IDX];
          s_nxt.st = ST_RUN;
          s_nxt.dbg_ack = 1'b0;
          s_nxt.decode_v = 1'b0;
          s_nxt.fetch_v = 1'b0;
        end
      end
      ST_LOAD:
      begin
        if (de)
        begin
          s_nxt.p1_v = 1'b1;
          s_nxt.p1_i = dpi_low_idx(s_r.list);
          s_nxt.p1_d = w;
          s_nxt.list[dpi_low_idx(s_r.list)] = 1'b0;
          s_nxt.left = s_r.left - 5'h01;
          if (s_r.left == 5'h01)
            s_nxt.st = ST_TAIL;
        end
      end
      ST_TAIL:
      begin
        if (de)
        begin
          s_nxt.tail = s_r.tail - 3'h1;
          if (s_r.tail == 3'h1)
            s_nxt.st = ST_HALT;
        end
      end
      ST_RUN:
      begin
        if (push)
        begin
          s_nxt.addr = s_r.addr + INSTR_BYTES;
          s_nxt.list[push_idx] = 1'b0;
        end
        else if (s_r.list == '0)
        begin
          s_nxt.gr[ADDR_REG_IDX] = s_r.addr;
          s_nxt.st = ST_DRAIN;
        end
      end
      ST_DRAIN:
      begin
        // Halt only after every write has left the buffer
        if (!fifo_valid)
        begin
          s_nxt.dbg_ack = 1'b1;
          s_nxt.st = ST_HALT;
        end
      end
      default: s_nxt.st = ST_HALT;
    endcase
    s_nxt.busy = s_nxt.st inside {ST_LOAD, ST_TAIL};
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.st <= ST_HALT;
      s_r.psw <= PSW_RESET;
      s_r.gr <= {16{REG_RESET}};
      s_r.dbg_ack <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  dpi_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(s_r.st == ST_RUN && s_r.list != '0),
    .in_ready_o(fifo_ready),
    .in_data_i({s_r.addr, s_r.gr[push_idx]}),
    .out_valid_o(fifo_valid),
    .out_ready_i(mem_wr_ready_i),
    .out_data_o(fifo_out)
  );

  assign psw_o = s_r.psw;
  assign reg_wr_o = s_r.reg_wr;
  assign reg_wr_idx_o = s_r.reg_idx;
  assign reg_wr_data_o = s_r.reg_data;
  assign load_busy_o = s_r.busy;
  // Memory request n is inactive exactly while the core is halted
  assign debug_acknowledge_o = s_r.dbg_ack;
  assign memory_request_n_o = s_r.dbg_ack;
  assign mem_wr_valid_o = fifo_valid;
  assign mem_wr_addr_o = fifo_out[63:32];
  assign mem_wr_data_o = fifo_out[31:0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  psw_update_a: assert property (de && exec_ok && s_r.decode == STATUS_WRITE_OP |=> psw_o == $past(gr0))
    else $error("status word not taken from register zero");
  psw_hold_a: assert property (!(de && exec_ok && s_r.decode == STATUS_WRITE_OP) |=> $stable(psw_o))
    else $error("status word changed without opcode in execute");
  load_start_a: assert property (de && exec_ok && s_r.decode[31:16] == LOAD_MULTI_HI && s_r.decode[15:0] != '0
    |=> s_r.st == ST_LOAD && load_busy_o)
    else $error("load-multiple did not start");
  load_data_a: assert property (de && s_r.st == ST_LOAD |=> s_r.p1_v && s_r.p1_d == $past(w))
    else $error("data word not accepted");
  write_lag_a: assert property (de && s_r.p2_v |=> reg_wr_o && reg_wr_idx_o == $past(p2_i)
    && reg_wr_data_o == $past(p2_d))
    else $error("register write missing");
  pc_tail_a: assert property (de && s_r.st == ST_LOAD && s_r.left == 5'h01 && s_r.list[PC_IDX]
    |=> s_r.tail == TAIL_EDGES_PC)
    else $error("program counter tail too short");
  write_pulse_a: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  mark_next_a: assert property (de && s_r.st == ST_HALT && s_r.mark |=> s_r.fetch_m)
    else $error("flag did not mark next instruction");
  store_start_a: assert property (re && !de && exec_ok && s_r.decode_m && s_r.decode[31:16] == STORE_MULTI_HI
    |=> !debug_acknowledge_o && !memory_request_n_o)
    else $error("flagged store did not resume");
  store_list_a: assert property (s_r.st == ST_RUN |-> (s_r.list & ~STORE_LIST_MASK) == '0)
    else $error("store list holds program counter");
  addr_step_a: assert property (push |=> s_r.addr == $past(addr) + INSTR_BYTES)
    else $error("store address did not advance");
  halt_flags_a: assert property (s_r.st == ST_DRAIN && !fifo_valid |=> debug_acknowledge_o && memory_request_n_o)
    else $error("halt flags not raised after store");

  pipe_shift_a: assert property (de && s_r.st inside {ST_HALT, ST_LOAD, ST_TAIL}
    |=> s_r.decode == $past(s_r.fetch) && s_r.fetch == $past(w))
    else $error("pipeline did not advance one stage");
  idle_hold_a: assert property (!de |=> $stable(s_r.decode) && $stable(s_r.fetch))
    else $error("pipeline moved without debug clock");
  speed_mark_a: assert property (de && s_r.st == ST_HALT |=> s_r.mark == $past(w_flag))
    else $error("system-speed flag not captured");
  no_store_a: assert property (re && !de && exec_ok && !s_r.decode_m |=> debug_acknowledge_o)
    else $error("unflagged instruction left debug state");
  data_order_a: assert property (de && s_r.st == ST_LOAD |=> s_r.p1_i == $past(push_idx))
    else $error("data word sent to wrong register");
  data_no_exec_a: assert property (de && s_r.st == ST_LOAD |=> !s_r.fetch_v)
    else $error("data word entered the pipeline as code");
  load_list_a: assert property (de && exec_ok && s_r.decode[31:16] == LOAD_MULTI_HI
    |=> s_r.list == $past(s_r.decode[15:0]) && s_r.left == $past(dpi_count(s_r.decode[15:0])))
    else $error("load list not taken from opcode");
  plain_tail_a: assert property (de && exec_ok && s_r.decode[31:16] == LOAD_MULTI_HI && !s_r.decode[PC_IDX]
    |=> s_r.tail == TAIL_EDGES)
    else $error("load tail length wrong");
  busy_end_a: assert property (de && s_r.st == ST_TAIL && s_r.tail == 3'h1
    |=> !load_busy_o && s_r.st == ST_HALT)
    else $error("load did not end after tail");
  status_stay_a: assert property (de && exec_ok && s_r.decode == STATUS_WRITE_OP
    |=> s_r.st == ST_HALT && !load_busy_o)
    else $error("status write left debug state");
  store_addr_a: assert property (re && !de && exec_ok && s_r.decode_m && s_r.decode[31:16] == STORE_MULTI_HI
    |=> s_r.addr == $past(s_r.gr[ADDR_REG_IDX]) && s_r.st == ST_RUN)
    else $error("store did not start at register fourteen");
  addr_back_a: assert property (s_r.st == ST_RUN && s_r.list == '0
    |=> s_r.gr[ADDR_REG_IDX] == $past(addr) && s_r.st == ST_DRAIN)
    else $error("register fourteen not updated");
  drain_wait_a: assert property (s_r.st == ST_DRAIN && fifo_valid |=> !debug_acknowledge_o)
    else $error("halt flags raised before writes drained");
  run_ack_a: assert property (s_r.st inside {ST_RUN, ST_DRAIN} |-> !debug_acknowledge_o && !memory_request_n_o)
    else $error("halt flags high during system-speed run");
  run_quiet_a: assert property (s_r.st == ST_RUN |=> !reg_wr_o)
    else $error("register write during system-speed run");
endmodule : dpi_sequencer
`default_nettype wire

// >>> dv/dpi_host_model.sv
// Debug host model: debug clock, scanned words, flag and resume
`timescale 1ns/1ns
`default_nettype none
module dpi_host_model (
  input wire logic sys_clk_i,
  input wire logic debug_acknowledge_i,
  input wire logic memory_request_n_i,
  output logic debug_clock_o,
  output logic resume_o,
  output logic [31:0] scan_word_o,
  output logic system_speed_flag_o
);
  initial
  begin
    debug_clock_o = 1'b0;
    resume_o = 1'b0;
    scan_word_o = 32'h00000000;
    system_speed_flag_o = 1'b0;
  end

  // One debug clock cycle per word; clock parked low between words
  task automatic push(input logic [31:0] w, input logic f);
    @(posedge sys_clk_i);
    scan_word_o <= w;
    system_speed_flag_o <= f;
    repeat (3) @(posedge sys_clk_i);
    debug_clock_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    debug_clock_o <= 1'b0;
    // Word and flag no longer held: show their inverse so a late sample is caught
    scan_word_o <= ~w;
    system_speed_flag_o <= ~f;
  endtask : push

  task automatic run(output logic started, output logic done);
    started = 1'b0;
    done = 1'b0;
    @(posedge sys_clk_i);
    resume_o <= 1'b1;
    for (int i = 0; i < 30 && !started; i++)
    begin
      @(posedge sys_clk_i);
      started = (debug_acknowledge_i === 1'b0);
    end
    for (int i = 0; i < 400 && started && !done; i++)
    begin
      @(posedge sys_clk_i);
      done = (debug_acknowledge_i === 1'b1) && (memory_request_n_i === 1'b1);
    end
    resume_o <= 1'b0;
  endtask : run
endmodule : dpi_host_model
`default_nettype wire

// >>> dv/debug_pipeline_inject_sequencer_tb_top.sv
// Self-checking bench for the debug pipeline inject sequencer
`timescale 1ns/1ns
`default_nettype none
module debug_pipeline_inject_sequencer_tb_top;
  import dpi_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic debug_clock, resume, flag, wr, busy, ack, mreq_n, mvalid, st, dn;
  logic ready = 1'b0;
  logic stall = 1'b0;
  logic chk_wr = 1'b0;
  logic [31:0] word, psw, wdata, maddr, mdata;
  logic [3:0] widx;
  logic [15:0] seed = 16'h005E;
  logic [15:0] rseed = 16'h005E;
  logic [31:0] reg_m [16];
  logic [31:0] psw_m = PSW_RESET;
  logic [35:0] wr_q [$];
  logic [63:0] mem_q [$];
  int mismatches = 0;
  int compares = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  // Small FIFO so the memory side back-pressures early
  dpi_sequencer #(.FIFO_WORDS(2)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .debug_clock_i(debug_clock), .resume_i(resume),
    .scan_word_i(word), .system_speed_flag_i(flag), .psw_o(psw), .reg_wr_o(wr),
    .reg_wr_idx_o(widx), .reg_wr_data_o(wdata), .load_busy_o(busy), .debug_acknowledge_o(ack),
    .memory_request_n_o(mreq_n), .mem_wr_valid_o(mvalid), .mem_wr_ready_i(ready),
    .mem_wr_addr_o(maddr), .mem_wr_data_o(mdata)
  );
  dpi_host_model u_host (
    .sys_clk_i(sys_clk_i), .debug_acknowledge_i(ack), .memory_request_n_i(mreq_n),
    .debug_clock_o(debug_clock), .resume_o(resume), .scan_word_o(word), .system_speed_flag_o(flag)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge sys_clk_i)
  begin
    ready <= !stall && rseed[0];
    rseed <= lfsr(rseed);
    if (chk_wr && wr === 1'b1)
    begin
      if (wr_q.size() == 0) chk(64'h1, 64'h0);
      else chk({widx, wdata}, wr_q.pop_front());
    end
    if (mvalid === 1'b1 && ready === 1'b1)
    begin
      if (mem_q.size() == 0) chk(64'h1, 64'h0);
      else chk({maddr, mdata}, mem_q.pop_front());
    end
  end

  // Debug speed only, no memory traffic
  task automatic load(input logic [15:0] list, input logic fix, input logic [31:0] v);
    logic [31:0] d [$];
    for (int i = 0; i < 16; i++)
      if (list[i])
      begin
        d.push_back(fix ? v : {seed, lfsr(seed)});
        seed = lfsr(lfsr(seed));
        reg_m[i] = d[$];
        wr_q.push_back({4'(i), d[$]});
      end
    chk_wr = 1'b1;
    u_host.push({LOAD_MULTI_HI, list}, 1'b0);
    u_host.push(32'h00000000, 1'b0);
    u_host.push(32'h00000000, 1'b0);
    repeat (6) @(posedge sys_clk_i);
    chk(busy, 1'b1);
    foreach (d[i]) u_host.push(d[i], 1'b0);
    repeat (list[15] ? 4 : 2) u_host.push(32'h00000000, 1'b0);
    repeat (6) @(posedge sys_clk_i);
    chk(busy, 1'b0);
    chk(wr_q.size(), 0);
    chk_wr = 1'b0;
  endtask : load

  task automatic status(input logic [31:0] v);
    logic [31:0] saved;
    saved = reg_m[0];
    load(16'h0001, 1'b1, v);
    u_host.push(STATUS_WRITE_OP, 1'b0);
    u_host.push(32'h00000000, 1'b0);
    repeat (6) @(posedge sys_clk_i);
    chk(psw, psw_m);
    u_host.push(32'h00000000, 1'b0);
    repeat (6) @(posedge sys_clk_i);
    psw_m = v;
    chk(psw, psw_m);
    load(16'h0001, 1'b1, saved);
  endtask : status

  // System speed run; hold stalls the memory side to fill the FIFO
  task automatic store(input logic [15:0] list, input logic mark, input logic hold);
    logic [31:0] a;
    a = reg_m[14];
    u_host.push(32'h00000000, 1'b0);
    u_host.push(32'h00000000, mark);
    u_host.push({STORE_MULTI_HI, list}, 1'b0);
    u_host.push(32'h00000000, 1'b0);
    for (int i = 0; i < 15 && mark; i++)
      if (list[i])
      begin
        mem_q.push_back({a, reg_m[i]});
        a = a + INSTR_BYTES;
      end
    reg_m[14] = a;
    stall <= hold;
    fork
      u_host.run(st, dn);
      begin
        repeat (30) @(posedge sys_clk_i);
        if (hold) chk(ack, 1'b0);
        stall <= 1'b0;
      end
    join
    chk({st, dn}, {mark, mark});
    chk(mem_q.size(), 0);
  endtask : store

  initial
  begin
    foreach (reg_m[i]) reg_m[i] = REG_RESET;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk({psw, ack, mreq_n, mvalid}, {PSW_RESET, 3'b110});
    load(16'h0003, 1'b0, 32'h00000000);
    load(16'h0000, 1'b0, 32'h00000000);
    status(32'h600000D3);
    load(16'hFFFF, 1'b0, 32'h00000000);
    store(16'h3FFF, 1'b1, 1'b1);
    load(16'hC005, 1'b0, 32'h00000000);
    store(16'h4005, 1'b1, 1'b0);
    store(16'h0005, 1'b1, 1'b0);
    store(16'h0001, 1'b0, 1'b0);
    wrap_up;
  end
endmodule : debug_pipeline_inject_sequencer_tb_top
`default_nettype wire
